// ### bench/serial_port_slave_select_sleep_tb.sv
// Purpose: host and device ends joined, spi and two-wire traffic
// Assumes: whichever end is master makes its link clock from the core clock
// Notes: outputs sampled on the falling edge, away from updates
`default_nettype none
module serial_port_slave_select_sleep_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, srst_i;
	logic en, sleep, ie, tx_wr, rx_rd, flag_clr, spi_go, i2c_go, i2c_read;
	logic [3:0] mode;
	logic [7:0] tx_data, spi_data, i2c_wdata;
	logic [6:0] i2c_addr;
	logic [7:0] rx_data, spi_rx, i2c_rdata;
	logic bf, pif, wake, fstart, rw, spi_busy, spi_done, i2c_busy, i2c_done, i2c_ack;
	logic fs_seen;
	int errors, checks_done, cyc_cnt;
	spss_link_if lnk();
	spss_host i_spss_host (.core_clk_i(core_clk_i), .srst_i(srst_i), .lnk(lnk.host),
		.spi_go_i(spi_go), .spi_data_i(spi_data), .spi_busy_o(spi_busy),
		.spi_done_o(spi_done), .spi_rx_o(spi_rx), .i2c_go_i(i2c_go),
		.i2c_addr_i(i2c_addr), .i2c_read_i(i2c_read), .i2c_wdata_i(i2c_wdata),
		.i2c_busy_o(i2c_busy), .i2c_done_o(i2c_done), .i2c_ack_o(i2c_ack),
		.i2c_rdata_o(i2c_rdata));
	spss_dev i_spss_dev (.core_clk_i(core_clk_i), .srst_i(srst_i), .lnk(lnk.dev),
		.port_enable_bit_i(en), .mode_select_field_i(mode), .sleep_i(sleep),
		.port_interrupt_enable_i(ie), .own_addr_i(7'h2A), .tx_wr_i(tx_wr),
		.tx_data_i(tx_data), .rx_rd_i(rx_rd), .flag_clr_i(flag_clr), .rx_data_o(rx_data),
		.buffer_full_flag_o(bf), .port_interrupt_flag_o(pif), .wake_o(wake),
		.frame_start_o(fstart), .i2c_rw_o(rw));
	spss_checker i_spss_checker (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.sck_dev_oe(lnk.sck_dev_oe), .sck(lnk.sck), .ss_n(lnk.ss_n), .sdo_oe(lnk.sdo_oe),
		.scl_dev_oe(lnk.scl_dev_oe), .scl(lnk.scl), .sda(lnk.sda));
	// ****************************************
	// clock, timeout, helpers
	// ****************************************
	initial begin
		core_clk_i = 1'h0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (fstart === 1'h1) fs_seen <= 1'h1;
		cyc_cnt <= cyc_cnt + 1;
		// ceiling well above the roughly two thousand cycles each two-wire message takes
		if (cyc_cnt == 40000) begin
			errors = errors + 1;
			give_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [3:0] m);
		tick(1);
		en <= 1'h0;
		mode <= m;
		tick(3);
		en <= 1'h1;
		tick(3);
	endtask
	task automatic load(input logic [7:0] d);
		tick(1);
		tx_data <= d;
		tx_wr <= 1'h1;
		tick(1);
		tx_wr <= 1'h0;
	endtask
	task automatic clr();
		tick(1);
		rx_rd <= 1'h1;
		flag_clr <= 1'h1;
		tick(1);
		rx_rd <= 1'h0;
		flag_clr <= 1'h0;
	endtask
	task automatic spi_xfer(input logic [7:0] d);
		int n;
		tick(1);
		spi_data <= d;
		spi_go <= 1'h1;
		tick(1);
		spi_go <= 1'h0;
		for (n = 0; n < 1000 && spi_done !== 1'h1; n++) @(negedge core_clk_i);
		tick(6);
		@(negedge core_clk_i);
	endtask
	task automatic i2c_xfer(input logic [6:0] a, input logic r, input logic [7:0] d);
		int n;
		tick(1);
		i2c_addr <= a;
		i2c_read <= r;
		i2c_wdata <= d;
		i2c_go <= 1'h1;
		tick(1);
		i2c_go <= 1'h0;
		for (n = 0; n < 3000 && i2c_done !== 1'h1; n++) @(negedge core_clk_i);
		tick(6);
		@(negedge core_clk_i);
	endtask
	task automatic give_verdict();
		if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [7:0] dtx [2];
		logic [7:0] htx [2];
		int n;
		dtx = '{8'hA5, 8'h5A};
		htx = '{8'h3C, 8'hC3};
		srst_i = 1'h1;
		{en, sleep, ie, tx_wr, rx_rd, flag_clr, spi_go, i2c_go, i2c_read} = 9'h000;
		mode = spss_pkg::MODE_SPI_SS;
		{tx_data, spi_data, i2c_wdata} = 24'h000000;
		i2c_addr = 7'h00;
		fs_seen = 1'h0;
		errors = 0;
		checks_done = 0;
		cyc_cnt = 0;
		tick(10);
		srst_i <= 1'h0;
		// slave with select; sample phase and clock edge bits stay clear
		cfg(spss_pkg::MODE_SPI_SS);
		// two frames back to back, each realigned by select
		for (int i = 0; i < 2; i++) begin
			load(dtx[i]);
			fs_seen <= 1'h0;
			spi_xfer(htx[i]);
			chk(spi_rx, dtx[i]);
			chk(rx_data, htx[i]);
			chk({6'h00, bf, pif}, 8'h03);
			chk({7'h00, fs_seen}, 8'h01);
			clr();
			@(negedge core_clk_i);
			chk({6'h00, bf, pif}, 8'h00);
		end
		// asleep: byte still lands; wake only with interrupt enabled
		tick(1);
		sleep <= 1'h1;
		ie <= 1'h1;
		spi_xfer(8'h81);
		chk({7'h00, wake}, 8'h01);
		tick(1);
		ie <= 1'h0;
		clr();
		spi_xfer(8'h7E);
		chk({7'h00, wake}, 8'h00);
		chk({7'h00, pif}, 8'h01);
		chk(rx_data, 8'h7E);
		tick(1);
		sleep <= 1'h0;
		clr();
		// master byte frozen by sleep, finishes after waking
		cfg(spss_pkg::MODE_SPI_MST);
		load(8'h99);
		tick(40);
		sleep <= 1'h1;
		tick(400);
		@(negedge core_clk_i);
		chk({7'h00, bf}, 8'h00);
		tick(1);
		sleep <= 1'h0;
		for (n = 0; n < 400 && bf !== 1'h1; n++) @(negedge core_clk_i);
		chk({7'h00, bf}, 8'h01);
		clr();
		// two-wire write, read and a foreign address
		cfg(spss_pkg::MODE_I2C_SLV);
		i2c_xfer(7'h2A, 1'h0, 8'h5A);
		chk({7'h00, i2c_ack}, 8'h01);
		chk(rx_data, 8'h5A);
		chk({7'h00, rw}, 8'h00);
		load(8'h96);
		i2c_xfer(7'h2A, 1'h1, 8'h00);
		chk({7'h00, i2c_ack}, 8'h01);
		chk(i2c_rdata, 8'h96);
		chk({7'h00, rw}, 8'h01);
		i2c_xfer(7'h2B, 1'h0, 8'h11);
		chk({7'h00, i2c_ack}, 8'h00);
		chk(rx_data, 8'h5A);
		give_verdict();
	end
endmodule // serial_port_slave_select_sleep_tb
`default_nettype wire

// ### bench/spss_checker.sv
// Purpose: link timing checks between host and device ends
// Assumes: select mode, master mode and two-wire slave used, never mode 5
// Notes: sampled on the core clock, both ends run from it
`default_nettype none
module spss_checker (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic sck_dev_oe,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic sdo_oe,
	input wire logic scl_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	property p_sel_release;
		ss_n && !sck_dev_oe |-> !sdo_oe;
	endproperty
	a_sel_release: assert property (p_sel_release) else $error("sdo driven with select high");
	property p_sel_drive;
		!ss_n |-> sdo_oe;
	endproperty
	a_sel_drive: assert property (p_sel_drive) else $error("sdo floats with select low");
	property p_idle_clk;
		ss_n && !sck_dev_oe |-> !sck;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("spi clock moves outside frame");
	property p_sel_setup;
		$fell(ss_n) |-> !sck [*8];
	endproperty
	a_sel_setup: assert property (p_sel_setup) else $error("clock too soon after select");
	property p_clk_high;
		$rose(sck) && !sck_dev_oe |=> sck [*8];
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("spi clock high phase short");
	property p_start;
		$fell(sda) && scl |-> ##[1:30] !scl;
	endproperty
	a_start: assert property (p_start) else $error("start not followed by clock low");
	property p_stop;
		$rose(sda) && scl |=> (sda && scl) [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("bus not idle after stop");
	property p_no_stretch;
		!scl_dev_oe;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("device pulls clock line");
endmodule // spss_checker
`default_nettype wire

// ### hw/spss_dev.sv
// Purpose: port device end, spi slave and master, two-wire slave
// Assumes: config inputs change only while the port is disabled
// Notes: spi slave shifter runs on the link clock, the rest on core_clk_i
`default_nettype none
// Functional notes
// - select sync mode only in code 0100
// - select low enables shifting and drives output
// - select high releases output at once
// - select high resets port, aborts partial byte
// - port reset clears bit counter, also disable
// - select falling edge starts new aligned transfer
// - master keeps select high until transfer
// - clock edge select needs select control
// - software keeps sample phase clear as slave
// - master transfer freezes during sleep, then resumes
// - slave shifts on external clock, flags bytes
// - enabled interrupt wakes device on byte
// - two-wire lines only pulled low, released high
// - start, address, then direction bit
// - start is data falling while clock high
// - bytes travel most significant bit first
// - direction one reads, zero writes
// - matching slave acknowledges, takes complementary role
// - acknowledge is data held low
// - stop is data rising while clock high
// - full byte goes to buffer, sets flags
module spss_dev (
	input wire logic core_clk_i,
	input wire logic srst_i,
	spss_link_if.dev lnk,
	input wire logic port_enable_bit_i,
	input wire logic [3:0] mode_select_field_i,
	input wire logic sleep_i,
	input wire logic port_interrupt_enable_i,
	input wire logic [6:0] own_addr_i,
	input wire logic tx_wr_i,
	input wire logic [7:0] tx_data_i,
	input wire logic rx_rd_i,
	input wire logic flag_clr_i,
	output logic [7:0] rx_data_o,
	output logic buffer_full_flag_o,
	output logic port_interrupt_flag_o,
	output logic wake_o,
	output logic frame_start_o,
	output logic i2c_rw_o
);
	// ****************************************
	// configuration
	// ****************************************
	logic en_q;
	logic [3:0] mode_q;
	logic slv_mode, ss_mode, mst_mode, i2c_mode, slv_off, link_rst;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			en_q <= 1'h0;
			mode_q <= spss_pkg::MODE_SPI_MST;
		end else begin
			en_q <= port_enable_bit_i;
			mode_q <= mode_select_field_i;
		end
	end
	assign ss_mode = en_q & (mode_q == spss_pkg::MODE_SPI_SS);
	assign slv_mode = ss_mode | (en_q & (mode_q == spss_pkg::MODE_SPI_NOSS));
	assign mst_mode = en_q & (mode_q == spss_pkg::MODE_SPI_MST);
	assign i2c_mode = en_q & (mode_q == spss_pkg::MODE_I2C_SLV);
	assign slv_off = ~slv_mode;
	// select high clears the shifter without any clock edge
	assign link_rst = slv_off | (ss_mode & lnk.ss_n);
	// ****************************************
	// spi slave, link clock domain
	// ****************************************
	logic [2:0] bit_cnt_q;
	logic [7:0] sh_in_q, rx_lnk_q, tx_sh_q, tx_buf_q;
	logic done_tgl_q;
	always_ff @(posedge lnk.sck or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_q <= spss_pkg::BIT_CNT_ZERO;
			sh_in_q <= 8'h00;
		end else begin
			bit_cnt_q <= bit_cnt_q + spss_pkg::BIT_CNT_ONE;
			sh_in_q <= {sh_in_q[6:0], lnk.sdi};
		end
	end
	// word held steady for eight link edges while the toggle crosses
	always_ff @(posedge lnk.sck or posedge slv_off) begin
		if (slv_off) begin
			rx_lnk_q <= 8'h00;
			done_tgl_q <= 1'h0;
		end else if (bit_cnt_q == spss_pkg::BIT_CNT_LAST) begin
			rx_lnk_q <= {sh_in_q[6:0], lnk.sdi};
			done_tgl_q <= ~done_tgl_q;
		end
	end
	// in select mode tx_buf_q only changes while no frame is active
	always_ff @(negedge lnk.sck or posedge link_rst) begin
		if (link_rst) begin
			tx_sh_q <= 8'h00;
		end else if (bit_cnt_q == spss_pkg::BIT_CNT_ONE) begin
			tx_sh_q <= {tx_buf_q[6:0], 1'h0};
		end else begin
			tx_sh_q <= {tx_sh_q[6:0], 1'h0};
		end
	end
	// ****************************************
	// crossings into core domain
	// ****************************************
	logic ss_s1_q, ss_s2_q, ss_s3_q, dt_s1_q, dt_s2_q, dt_s3_q, sdi_s1_q, sdi_s2_q;
	logic spi_evt;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ss_s1_q <= 1'h1;
			ss_s2_q <= 1'h1;
			ss_s3_q <= 1'h1;
			dt_s1_q <= 1'h0;
			dt_s2_q <= 1'h0;
			dt_s3_q <= 1'h0;
			sdi_s1_q <= 1'h0;
			sdi_s2_q <= 1'h0;
			frame_start_o <= 1'h0;
		end else begin
			ss_s1_q <= lnk.ss_n;
			ss_s2_q <= ss_s1_q;
			ss_s3_q <= ss_s2_q;
			dt_s1_q <= done_tgl_q;
			dt_s2_q <= dt_s1_q;
			dt_s3_q <= dt_s2_q;
			sdi_s1_q <= lnk.sdi;
			sdi_s2_q <= sdi_s1_q;
			frame_start_o <= ss_mode & ss_s3_q & ~ss_s2_q;
		end
	end
	assign spi_evt = slv_mode & (dt_s2_q ^ dt_s3_q);
	// ****************************************
	// spi master, halted in sleep
	// ****************************************
	logic mst_busy_q, sck_q, mst_evt_q;
	logic [7:0] div_q, m_sh_q, m_in_q;
	logic [4:0] edge_q;
	always_ff @(posedge core_clk_i) begin
		if (srst_i | ~mst_mode) begin
			mst_busy_q <= 1'h0;
			sck_q <= 1'h0;
			mst_evt_q <= 1'h0;
			div_q <= 8'h00;
			edge_q <= 5'h00;
			m_sh_q <= 8'h00;
			m_in_q <= 8'h00;
		end else begin
			mst_evt_q <= 1'h0;
			if (!mst_busy_q) begin
				if (tx_wr_i) begin
					mst_busy_q <= 1'h1;
					m_sh_q <= tx_data_i;
					div_q <= 8'h00;
					edge_q <= 5'h00;
				end
			end else if (!sleep_i) begin
				if (div_q == spss_pkg::SCK_HALF_CYC - 8'h01) begin
					div_q <= 8'h00;
					sck_q <= ~sck_q;
					edge_q <= edge_q + 5'h01;
					if (!sck_q) begin
						m_in_q <= {m_in_q[6:0], sdi_s2_q};
					end else begin
						m_sh_q <= {m_sh_q[6:0], 1'h0};
					end
					if (edge_q == spss_pkg::SCK_EDGE_LAST) begin
						mst_busy_q <= 1'h0;
						mst_evt_q <= 1'h1;
					end
				end else begin
					div_q <= div_q + 8'h01;
				end
			end
		end
	end
	assign lnk.sck_dev = sck_q;
	assign lnk.sck_dev_oe = mst_mode;
	assign lnk.sdo_dev = mst_mode ? m_sh_q[7] :
		((bit_cnt_q == spss_pkg::BIT_CNT_ZERO) ? tx_buf_q[7] : tx_sh_q[7]);
	assign lnk.sdo_oe = mst_mode | (slv_mode & ~(ss_mode & lnk.ss_n));
	// ****************************************
	// two-wire slave
	// ****************************************
	spss_pkg::spss_slv_e st_q;
	logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
	logic sda_oe_q, i2c_evt_q;
	logic [3:0] i_cnt_q;
	logic [7:0] i_sh_q, i_tx_q;
	logic rise, fall, start, stop;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			scl_s1_q <= 1'h1;
			scl_s2_q <= 1'h1;
			scl_s3_q <= 1'h1;
			sda_s1_q <= 1'h1;
			sda_s2_q <= 1'h1;
			sda_s3_q <= 1'h1;
		end else begin
			scl_s1_q <= lnk.scl;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= lnk.sda;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end
	assign rise = scl_s2_q & ~scl_s3_q;
	assign fall = ~scl_s2_q & scl_s3_q;
	assign start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	always_ff @(posedge core_clk_i) begin
		if (srst_i | ~i2c_mode) begin
			st_q <= spss_pkg::SLV_IDLE;
			i_cnt_q <= 4'h0;
			i_sh_q <= 8'h00;
			i_tx_q <= 8'h00;
			sda_oe_q <= 1'h0;
			i2c_evt_q <= 1'h0;
			i2c_rw_o <= 1'h0;
		end else begin
			i2c_evt_q <= 1'h0;
			if (start) begin
				st_q <= spss_pkg::SLV_ADDR;
				i_cnt_q <= 4'h0;
				sda_oe_q <= 1'h0;
			end else if (stop) begin
				st_q <= spss_pkg::SLV_IDLE;
				sda_oe_q <= 1'h0;
			end else begin
				case (st_q)
					spss_pkg::SLV_ADDR, spss_pkg::SLV_RECV: begin
						if (rise) begin
							i_sh_q <= {i_sh_q[6:0], sda_s2_q};
							i_cnt_q <= i_cnt_q + 4'h1;
						end else if (fall && i_cnt_q == spss_pkg::I2C_BITS) begin
							if (st_q == spss_pkg::SLV_RECV) begin
								i2c_evt_q <= 1'h1;
								sda_oe_q <= 1'h1;
								st_q <= spss_pkg::SLV_RACK;
							end else if (i_sh_q[7:1] == own_addr_i) begin
								sda_oe_q <= 1'h1;
								i2c_rw_o <= i_sh_q[0];
								st_q <= spss_pkg::SLV_ACK;
							end else begin
								st_q <= spss_pkg::SLV_IDLE;
							end
						end
					end
					spss_pkg::SLV_ACK, spss_pkg::SLV_RACK, spss_pkg::SLV_MACK: begin
						if (rise && st_q == spss_pkg::SLV_MACK && sda_s2_q) begin
							st_q <= spss_pkg::SLV_IDLE;
						end else if (fall) begin
							i_cnt_q <= 4'h0;
							if (st_q == spss_pkg::SLV_RACK ||
								(st_q == spss_pkg::SLV_ACK && !i2c_rw_o)) begin
								sda_oe_q <= 1'h0;
								st_q <= spss_pkg::SLV_RECV;
							end else begin
								sda_oe_q <= ~tx_buf_q[7];
								i_tx_q <= {tx_buf_q[6:0], 1'h1};
								st_q <= spss_pkg::SLV_XMIT;
							end
						end
					end
					spss_pkg::SLV_XMIT: begin
						if (rise) begin
							i_cnt_q <= i_cnt_q + 4'h1;
						end else if (fall && i_cnt_q == spss_pkg::I2C_BITS) begin
							sda_oe_q <= 1'h0;
							st_q <= spss_pkg::SLV_MACK;
						end else if (fall) begin
							sda_oe_q <= ~i_tx_q[7];
							i_tx_q <= {i_tx_q[6:0], 1'h1};
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
	assign lnk.sda_dev_oe = sda_oe_q;
	// no clock stretching: the core always keeps up at this bit rate
	assign lnk.scl_dev_oe = 1'h0;
	// ****************************************
	// buffers, flags and wake
	// ****************************************
	logic byte_evt, tx_busy;
	logic [7:0] byte_val;
	assign byte_evt = spi_evt | mst_evt_q | i2c_evt_q;
	assign byte_val = spi_evt ? rx_lnk_q : (mst_evt_q ? m_in_q : i_sh_q);
	assign tx_busy = (ss_mode & ~ss_s2_q) | mst_busy_q |
		(st_q == spss_pkg::SLV_XMIT) | (st_q == spss_pkg::SLV_MACK);
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_buf_q <= 8'h00;
		end else if (tx_wr_i && !tx_busy) begin
			tx_buf_q <= tx_data_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rx_data_o <= 8'h00;
			buffer_full_flag_o <= 1'h0;
			port_interrupt_flag_o <= 1'h0;
			wake_o <= 1'h0;
		end else begin
			if (byte_evt) begin
				rx_data_o <= byte_val;
			end
			// a new byte wins over a clear in the same cycle
			buffer_full_flag_o <= byte_evt | (buffer_full_flag_o & ~rx_rd_i);
			port_interrupt_flag_o <= byte_evt | (port_interrupt_flag_o & ~flag_clr_i);
			wake_o <= sleep_i & port_interrupt_enable_i &
				(byte_evt | port_interrupt_flag_o);
		end
	end
endmodule // spss_dev
`default_nettype wire

// ### hw/spss_host.sv
// Purpose: bus partner, spi master and two-wire master
// Assumes: device never stretches the two-wire clock
// Notes: one two-wire message is address, one data byte, stop
`default_nettype none
module spss_host (
	input wire logic core_clk_i,
	input wire logic srst_i,
	spss_link_if.host lnk,
	input wire logic spi_go_i,
	input wire logic [7:0] spi_data_i,
	output logic spi_busy_o,
	output logic spi_done_o,
	output logic [7:0] spi_rx_o,
	input wire logic i2c_go_i,
	input wire logic [6:0] i2c_addr_i,
	input wire logic i2c_read_i,
	input wire logic [7:0] i2c_wdata_i,
	output logic i2c_busy_o,
	output logic i2c_done_o,
	output logic i2c_ack_o,
	output logic [7:0] i2c_rdata_o
);
	// ****************************************
	// spi master
	// ****************************************
	logic miso_s1_q, miso_s2_q, sck_q, ss_n_q, sdi_q;
	logic [7:0] div_q, sh_q;
	logic [4:0] edge_q;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			miso_s1_q <= 1'h1;
			miso_s2_q <= 1'h1;
		end else begin
			miso_s1_q <= lnk.sdo;
			miso_s2_q <= miso_s1_q;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			spi_busy_o <= 1'h0;
			spi_done_o <= 1'h0;
			spi_rx_o <= 8'h00;
			ss_n_q <= 1'h1;
			sck_q <= 1'h0;
			sdi_q <= 1'h0;
			div_q <= 8'h00;
			edge_q <= 5'h00;
			sh_q <= 8'h00;
		end else begin
			spi_done_o <= 1'h0;
			if (!spi_busy_o) begin
				if (spi_go_i) begin
					spi_busy_o <= 1'h1;
					ss_n_q <= 1'h0;
					sh_q <= spi_data_i;
					sdi_q <= spi_data_i[7];
					div_q <= 8'h00;
					edge_q <= 5'h00;
				end
			end else if (div_q == spss_pkg::SCK_HALF_CYC - 8'h01) begin
				div_q <= 8'h00;
				if (edge_q == spss_pkg::SCK_EDGE_END) begin
					spi_busy_o <= 1'h0;
					ss_n_q <= 1'h1;
					spi_done_o <= 1'h1;
				end else begin
					edge_q <= edge_q + 5'h01;
					sck_q <= ~sck_q;
					if (!sck_q) begin
						spi_rx_o <= {spi_rx_o[6:0], miso_s2_q};
					end else begin
						sh_q <= {sh_q[6:0], 1'h0};
						sdi_q <= sh_q[6];
					end
				end
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end
	assign lnk.sck_host = sck_q;
	assign lnk.ss_n = ss_n_q;
	assign lnk.sdi = sdi_q;
	// ****************************************
	// two-wire master
	// ****************************************
	spss_pkg::spss_mst_e st_q;
	logic sda_s1_q, sda_s2_q, scl_oe_q, sda_oe_q, rd_q;
	logic [7:0] qdiv_q;
	logic [1:0] qtr_q;
	logic [4:0] slot_q;
	logic [17:0] tx_q, rx_q;
	logic tick;
	assign tick = (qdiv_q == spss_pkg::I2C_QTR_CYC - 8'h01);
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sda_s1_q <= 1'h1;
			sda_s2_q <= 1'h1;
		end else begin
			sda_s1_q <= lnk.sda;
			sda_s2_q <= sda_s1_q;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q <= spss_pkg::MST_IDLE;
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
			rd_q <= 1'h0;
			qdiv_q <= 8'h00;
			qtr_q <= spss_pkg::QTR_0;
			slot_q <= 5'h00;
			tx_q <= 18'h00000;
			rx_q <= 18'h00000;
			i2c_busy_o <= 1'h0;
			i2c_done_o <= 1'h0;
			i2c_ack_o <= 1'h0;
			i2c_rdata_o <= 8'h00;
		end else begin
			i2c_done_o <= 1'h0;
			qdiv_q <= (st_q == spss_pkg::MST_IDLE || tick) ? 8'h00 : qdiv_q + 8'h01;
			if (tick) begin
				qtr_q <= qtr_q + 2'h1;
			end
			case (st_q)
				spss_pkg::MST_IDLE: begin
					qtr_q <= spss_pkg::QTR_0;
					if (i2c_go_i) begin
						// address, direction, ack slot, data, ack slot
						tx_q <= {i2c_addr_i, i2c_read_i, 1'h1,
							(i2c_read_i ? 8'hFF : i2c_wdata_i), 1'h1};
						rd_q <= i2c_read_i;
						slot_q <= 5'h00;
						i2c_busy_o <= 1'h1;
						st_q <= spss_pkg::MST_START;
					end
				end
				spss_pkg::MST_START: begin
					if (tick && qtr_q == spss_pkg::QTR_0) begin
						sda_oe_q <= 1'h1;
					end else if (tick && qtr_q == spss_pkg::QTR_1) begin
						scl_oe_q <= 1'h1;
						qtr_q <= spss_pkg::QTR_0;
						st_q <= spss_pkg::MST_BITS;
					end
				end
				spss_pkg::MST_BITS: begin
					if (tick && qtr_q == spss_pkg::QTR_0) begin
						sda_oe_q <= ~tx_q[17];
					end else if (tick && qtr_q == spss_pkg::QTR_1) begin
						scl_oe_q <= 1'h0;
					end else if (tick && qtr_q == spss_pkg::QTR_2) begin
						rx_q <= {rx_q[16:0], sda_s2_q};
					end else if (tick) begin
						scl_oe_q <= 1'h1;
						tx_q <= {tx_q[16:0], 1'h1};
						slot_q <= slot_q + 5'h01;
						if (slot_q == spss_pkg::I2C_SLOT_LAST) begin
							st_q <= spss_pkg::MST_STOP;
						end
					end
				end
				spss_pkg::MST_STOP: begin
					if (tick && qtr_q == spss_pkg::QTR_0) begin
						sda_oe_q <= 1'h1;
					end else if (tick && qtr_q == spss_pkg::QTR_1) begin
						scl_oe_q <= 1'h0;
					end else if (tick) begin
						sda_oe_q <= 1'h0;
						i2c_busy_o <= 1'h0;
						i2c_done_o <= 1'h1;
						i2c_ack_o <= ~rx_q[spss_pkg::I2C_AACK_BIT] &
							(rd_q | ~rx_q[spss_pkg::I2C_DACK_BIT]);
						i2c_rdata_o <= rx_q[8:1];
						st_q <= spss_pkg::MST_IDLE;
					end
				end
				default: begin
					st_q <= spss_pkg::MST_IDLE;
				end
			endcase
		end
	end
	assign lnk.scl_host_oe = scl_oe_q;
	assign lnk.sda_host_oe = sda_oe_q;
endmodule // spss_host
`default_nettype wire

// ### include/spss_link_if.sv
// Purpose: wires between the port device and its bus partner
// Assumes: pull-ups on the two-wire lines and on the data output
// Notes: open-drain lines are low while any enable is high
`default_nettype none
interface spss_link_if;
	logic sck_host;
	logic sck_dev;
	logic sck_dev_oe;
	logic sck;
	logic ss_n;
	logic sdi;
	logic sdo_dev;
	logic sdo_oe;
	logic sdo;
	logic scl_host_oe;
	logic scl_dev_oe;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic sda;
	assign sck = sck_dev_oe ? sck_dev : sck_host;
	assign sdo = sdo_oe ? sdo_dev : 1'h1;
	assign scl = ~(scl_host_oe | scl_dev_oe);
	assign sda = ~(sda_host_oe | sda_dev_oe);
	modport dev (
		input sck, ss_n, sdi, scl, sda,
		output sck_dev, sck_dev_oe, sdo_dev, sdo_oe, scl_dev_oe, sda_dev_oe
	);
	modport host (
		input sdo, scl, sda,
		output sck_host, ss_n, sdi, scl_host_oe, sda_host_oe
	);
endinterface
`default_nettype wire

// ### include/spss_pkg.sv
// Purpose: shared constants and state codes of the serial port link
// Assumes: 25 MHz core clock on both ends
// Notes: mode codes follow the four-bit mode select field
`default_nettype none
package spss_pkg;
	localparam int CORE_CLK_HZ = 25_000_000;
	localparam int CORE_CLK_NS = 40;
	// mode select field codes
	localparam logic [3:0] MODE_SPI_MST = 4'h0;
	localparam logic [3:0] MODE_SPI_SS = 4'h4;
	localparam logic [3:0] MODE_SPI_NOSS = 4'h5;
	localparam logic [3:0] MODE_I2C_SLV = 4'h6;
	// bit counting
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [2:0] BIT_CNT_ONE = 3'h1;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [3:0] I2C_BITS = 4'h8;
	// spi clock made by whichever end is master
	localparam int SCK_HZ = 1_000_000;
	localparam logic [7:0] SCK_HALF_CYC = 8'(CORE_CLK_HZ / (2 * SCK_HZ));
	localparam logic [4:0] SCK_EDGE_LAST = 5'h0F;
	localparam logic [4:0] SCK_EDGE_END = 5'h10;
	// two-wire bus quarter bit time, least time so rounded up
	localparam int I2C_QTR_NS = 1000;
	localparam logic [7:0] I2C_QTR_CYC = 8'((I2C_QTR_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
	localparam logic [4:0] I2C_SLOT_LAST = 5'h11;
	localparam int I2C_AACK_BIT = 9;
	localparam int I2C_DACK_BIT = 0;
	localparam logic [1:0] QTR_0 = 2'h0;
	localparam logic [1:0] QTR_1 = 2'h1;
	localparam logic [1:0] QTR_2 = 2'h2;
	localparam logic [1:0] QTR_3 = 2'h3;
	typedef enum logic [6:0] {
		SLV_IDLE = 7'h01,
		SLV_ADDR = 7'h02,
		SLV_ACK = 7'h04,
		SLV_RECV = 7'h08,
		SLV_RACK = 7'h10,
		SLV_XMIT = 7'h20,
		SLV_MACK = 7'h40
	} spss_slv_e;
	typedef enum logic [3:0] {
		MST_IDLE = 4'h1,
		MST_START = 4'h2,
		MST_BITS = 4'h4,
		MST_STOP = 4'h8
	} spss_mst_e;
endpackage
`default_nettype wire
